/* hw/epc_pkg.sv */
// Purpose: Constants for the configuration map loader and wake pin logic
// Assumes: Byte-wide configuration image, 40 MHz system clock
// Notes:   Register offsets are byte addresses on the AXI4-Lite slave
package epc_pkg;
   localparam int unsigned CLK_HZ          = 40000000;
   // Map byte addresses
   localparam logic [7:0] MAP_PME_FLAGS    = 8'h09;
   localparam logic [7:0] MAP_IF_STR_OFS   = 8'h2e;
   localparam logic [7:0] MAP_BOS_LEN      = 8'h2f;
   localparam logic [7:0] MAP_BOS_OFS      = 8'h30;
   localparam logic [7:0] MAP_HS_DEV_LEN   = 8'h35;
   localparam logic [7:0] MAP_FS_CFG_OFS   = 8'h3c;
   localparam logic [7:0] MAP_WFF_LEN      = 8'h3d;
   localparam logic [7:0] MAP_WFF_OFS      = 8'h3e;
   localparam logic [7:0] MAP_SW_LEN       = 8'h46;
   localparam logic [7:0] MAP_SW_OFS       = 8'h47;
   localparam logic [7:0] WFF_CFG_BYTES    = 8'h04;
   localparam logic [7:0] WFF_MASK_BYTES   = 8'h10;
   // Flag byte fields
   localparam int unsigned FLG_EN          = 7;
   localparam int unsigned FLG_PULSE       = 6;
   localparam int unsigned FLG_LONG        = 5;
   localparam int unsigned FLG_POL         = 4;
   localparam int unsigned FLG_PP          = 3;
   localparam int unsigned FLG_LINK        = 2;
   localparam int unsigned FLG_PKT         = 1;
   localparam int unsigned FLG_DA          = 0;
   // Pulse lengths in microseconds
   localparam int unsigned PULSE_SHORT_US  = 1500;
   localparam int unsigned PULSE_LONG_US   = 150000;
   localparam int unsigned PULSE_SHORT_CYC = PULSE_SHORT_US * (CLK_HZ / 1000000);
   localparam int unsigned PULSE_LONG_CYC  = PULSE_LONG_US * (CLK_HZ / 1000000);
   // AXI4-Lite register byte addresses
   localparam logic [7:0] REG_CTRL         = 8'h00;
   localparam logic [7:0] REG_STATUS       = 8'h04;
   localparam logic [7:0] REG_FLAGS        = 8'h08;
   localparam logic [7:0] REG_BOS          = 8'h0c;
   localparam logic [7:0] REG_DESC_HS      = 8'h10;
   localparam logic [7:0] REG_DESC_FS      = 8'h14;
   localparam logic [7:0] REG_WFF_CFG      = 8'h18;
   localparam logic [7:0] REG_WFF_MASK0    = 8'h1c;
   localparam logic [7:0] REG_SW           = 8'h2c;
   localparam logic [7:0] REG_IF_STR       = 8'h30;
   localparam logic [1:0] RESP_OKAY        = 2'b00;
   localparam logic [1:0] RESP_SLVERR      = 2'b10;
endpackage

/* hw/epc_sync.sv */
// Purpose: Two-stage synchroniser for a bus of asynchronous levels
// Assumes: Inputs are levels from outside the clock domain
// Notes:   First stage feeds only the second stage
`timescale 1ns/100ps
module epc_sync #(
   parameter int unsigned W = 1
) (
   input  wire logic         aclk,
   input  wire logic         aresetn,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   logic [W-1:0] meta_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_q <= '0;
         dout   <= '0;
      end else begin
         meta_q <= din;
         dout   <= meta_q;
      end
   end
endmodule

/* hw/epc_wake.sv */
// Purpose: Wake request pin driver, level or fixed-length pulse
// Assumes: Flag byte valid once flags_valid is high
// Notes:   Pulse counts cycles from the first event only
`timescale 1ns/100ps
module epc_wake #(
   parameter int unsigned SHORT_CYC = epc_pkg::PULSE_SHORT_CYC,
   parameter int unsigned LONG_CYC  = epc_pkg::PULSE_LONG_CYC
) (
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic       flags_valid,
   input  wire logic [7:0] flags,
   input  wire logic       wake_event,
   input  wire logic       level_clear,
   output logic            wake_o,
   output logic            wake_oe_n,
   output logic            active
);
   logic [22:0] cnt_q;
   logic        act_q;
   logic        en;

   assign en     = flags_valid & flags[epc_pkg::FLG_EN];
   assign active = act_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         act_q <= 1'b0;
         cnt_q <= '0;
      end else if (!en) begin
         act_q <= 1'b0;
         cnt_q <= '0;
      end else if (flags[epc_pkg::FLG_PULSE]) begin
         if (!act_q && wake_event) begin
            act_q <= 1'b1;
            cnt_q <= flags[epc_pkg::FLG_LONG] ? 23'(LONG_CYC - 1) : 23'(SHORT_CYC - 1);
         end else if (act_q) begin
            if (cnt_q == '0) begin
               act_q <= 1'b0;
            end else begin
               cnt_q <= cnt_q - 23'h1;
            end
         end
      end else begin
         if (wake_event) begin
            act_q <= 1'b1;
         end else if (level_clear) begin
            act_q <= 1'b0;
         end
      end
   end

   // Pin drive from flip-flops; inactive until flags are loaded
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wake_o    <= 1'b0;
         wake_oe_n <= 1'b1;
      end else if (!en) begin
         wake_o    <= 1'b0;
         wake_oe_n <= 1'b1;
      end else if (flags[epc_pkg::FLG_PP]) begin
         wake_o    <= act_q ~^ flags[epc_pkg::FLG_POL];
         wake_oe_n <= 1'b0;
      end else begin
         wake_o    <= 1'b0;
         wake_oe_n <= ~(act_q & ~flags[epc_pkg::FLG_POL]);
      end
   end
endmodule

/* hw/epc_top.sv */
// What this block does
// - Enabled flag asserts wake pin on events
// - Enable bit zero ignores other wake flags
// - Bit 6 picks level or pulse signalling
// - Bit 5 picks 1.5 ms or 150 ms
// - Pulse timed from first event, never extended
// - Bit 4 sets active polarity; with open drain, active high leaves the pin undriven
// - Bit 3 picks open drain or push-pull
// - Bit 2 enables link change wake source
// - Bit 1 enables packet wake source
// - Bit 0 enables exact destination wake source
// - Interface string offset read from 2Eh
// - BOS length 2Fh, offset 30h, then fetched
// - Descriptor pairs read from 35h-3Ch
// - Filter 0: four config, sixteen mask bytes
// - SW descriptor length 46h, offset 47h
//
// Purpose: Configuration image loader with wake request pin control
// Assumes: Image memory answers a byte read one cycle after the request
// Notes:   Registers reached over AXI4-Lite; events arrive asynchronously
`timescale 1ns/100ps
module epc_top #(
   parameter int unsigned SHORT_CYC = epc_pkg::PULSE_SHORT_CYC,
   parameter int unsigned LONG_CYC  = epc_pkg::PULSE_LONG_CYC
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic             img_rd,
   output logic [8:0]       img_addr,
   input  wire logic [7:0]  img_data,
   input  wire logic        gpio_wake_evt,
   input  wire logic        packet_evt,
   input  wire logic        wake_frame_filter_match,
   input  wire logic        exact_destination_match,
   input  wire logic        link_change_evt,
   output logic             wake_request_pin_o,
   output logic             wake_request_pin_oe_n,
   output logic             load_done
);
   typedef enum logic [5:0] {
      EPC_IDLE = 6'b000001,
      EPC_HDR  = 6'b000010,
      EPC_WFF  = 6'b000100,
      EPC_BOS  = 6'b001000,
      EPC_DONE = 6'b010000,
      EPC_WAIT = 6'b100000
   } epc_state_t;

   epc_state_t  st_q;
   logic [7:0]  hdr_idx_q;
   logic [7:0]  blk_idx_q;
   logic        rd_pend_q;
   logic [7:0]  pend_addr_q;
   logic        in_wff_q;
   logic        in_bos_q;
   logic [7:0]  flags_q;
   logic        flags_valid_q;
   logic [7:0]  if_str_ofs_q;
   logic [7:0]  bos_len_q;
   logic [7:0]  bos_ofs_q;
   logic [7:0]  bos_sum_q;
   logic [7:0]  desc_q [0:7];
   logic [7:0]  wff_len_q;
   logic [7:0]  wff_ofs_q;
   logic [7:0]  wff_q [0:19];
   logic [7:0]  sw_len_q;
   logic [7:0]  sw_ofs_q;
   logic        reload_q;
   logic        level_clr_q;
   logic [4:0]  evt_raw;
   logic [4:0]  evt_s;
   logic [4:0]  evt_prev_q;
   logic        wake_evt;
   logic        wake_act;
   logic        aw_hold_q;
   logic        w_hold_q;
   logic [7:0]  aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0]  w_strb_q;

   function automatic logic [8:0] word_addr(input logic [7:0] ofs, input logic [7:0] idx);
      word_addr = 9'({ofs, 1'b0}) + 9'(idx);
   endfunction

   function automatic logic [31:0] pack4(input logic [7:0] b0, input logic [7:0] b1,
                                         input logic [7:0] b2, input logic [7:0] b3);
      pack4 = {b3, b2, b1, b0};
   endfunction

   // Image read sequencer
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q      <= EPC_IDLE;
         hdr_idx_q <= '0;
         blk_idx_q <= '0;
         img_rd    <= 1'b0;
         img_addr  <= '0;
         rd_pend_q <= 1'b0;
         in_wff_q  <= 1'b0;
         in_bos_q  <= 1'b0;
         pend_addr_q <= '0;
         load_done <= 1'b0;
      end else begin
         img_rd    <= 1'b0;
         rd_pend_q <= img_rd;
         case (st_q)
            EPC_IDLE: begin
               load_done <= 1'b0;
               hdr_idx_q <= epc_pkg::MAP_PME_FLAGS;
               st_q      <= EPC_HDR;
            end
            EPC_HDR: begin
               if (!img_rd && !rd_pend_q) begin
                  if (hdr_idx_q > epc_pkg::MAP_SW_OFS) begin
                     blk_idx_q <= '0;
                     st_q      <= EPC_WFF;
                  end else begin
                     img_rd      <= 1'b1;
                     img_addr    <= {1'b0, hdr_idx_q};
                     pend_addr_q <= hdr_idx_q;
                     hdr_idx_q   <= (hdr_idx_q == epc_pkg::MAP_PME_FLAGS) ?
                                    epc_pkg::MAP_IF_STR_OFS : hdr_idx_q + 8'h01;
                  end
               end
            end
            EPC_WFF: begin
               if (!img_rd && !rd_pend_q) begin
                  if (wff_len_q == '0 || blk_idx_q ==
                      epc_pkg::WFF_CFG_BYTES + epc_pkg::WFF_MASK_BYTES) begin
                     in_wff_q  <= 1'b0;
                     blk_idx_q <= '0;
                     st_q      <= EPC_BOS;
                  end else begin
                     in_wff_q  <= 1'b1;
                     img_rd    <= 1'b1;
                     img_addr  <= word_addr(wff_ofs_q, blk_idx_q);
                     pend_addr_q <= blk_idx_q;
                     blk_idx_q <= blk_idx_q + 8'h01;
                  end
               end
            end
            EPC_BOS: begin
               if (!img_rd && !rd_pend_q) begin
                  if (blk_idx_q == bos_len_q) begin
                     in_bos_q <= 1'b0;
                     st_q     <= EPC_DONE;
                  end else begin
                     in_bos_q  <= 1'b1;
                     img_rd    <= 1'b1;
                     img_addr  <= word_addr(bos_ofs_q, blk_idx_q);
                     blk_idx_q <= blk_idx_q + 8'h01;
                  end
               end
            end
            EPC_DONE: begin
               load_done <= 1'b1;
               st_q      <= EPC_WAIT;
            end
            EPC_WAIT: begin
               if (reload_q) begin
                  st_q <= EPC_IDLE;
               end
            end
            default: st_q <= EPC_IDLE;
         endcase
      end
   end

   // Capture of returned image bytes
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flags_q       <= '0;
         flags_valid_q <= 1'b0;
         if_str_ofs_q  <= '0;
         bos_len_q     <= '0;
         bos_ofs_q     <= '0;
         bos_sum_q     <= '0;
         wff_len_q     <= '0;
         wff_ofs_q     <= '0;
         sw_len_q      <= '0;
         sw_ofs_q      <= '0;
         for (int i = 0; i < 8; i++) desc_q[i] <= '0;
         for (int i = 0; i < 20; i++) wff_q[i] <= '0;
      end else begin
         if (st_q == EPC_IDLE) begin
            flags_valid_q <= 1'b0;
            bos_sum_q     <= '0;
         end
         if (rd_pend_q && st_q == EPC_HDR) begin
            case (pend_addr_q)
               epc_pkg::MAP_PME_FLAGS: begin
                  flags_q       <= img_data;
                  flags_valid_q <= 1'b1;
               end
               epc_pkg::MAP_IF_STR_OFS: if_str_ofs_q <= img_data;
               epc_pkg::MAP_BOS_LEN:    bos_len_q    <= img_data;
               epc_pkg::MAP_BOS_OFS:    bos_ofs_q    <= img_data;
               epc_pkg::MAP_WFF_LEN:    wff_len_q    <= img_data;
               epc_pkg::MAP_WFF_OFS:    wff_ofs_q    <= img_data;
               epc_pkg::MAP_SW_LEN:     sw_len_q     <= img_data;
               epc_pkg::MAP_SW_OFS:     sw_ofs_q     <= img_data;
               default: begin
                  if (pend_addr_q >= epc_pkg::MAP_HS_DEV_LEN &&
                      pend_addr_q <= epc_pkg::MAP_FS_CFG_OFS) begin
                     desc_q[3'(pend_addr_q - epc_pkg::MAP_HS_DEV_LEN)] <= img_data;
                  end
               end
            endcase
         end
         if (rd_pend_q && in_wff_q && pend_addr_q < 8'h14) begin
            wff_q[5'(pend_addr_q)] <= img_data;
         end
         if (rd_pend_q && in_bos_q) begin
            bos_sum_q <= bos_sum_q + img_data;
         end
      end
   end

   // Wake sources
   assign evt_raw = {link_change_evt, exact_destination_match, wake_frame_filter_match,
                     packet_evt, gpio_wake_evt};

   epc_sync #(.W(5)) u_sync (
      .aclk    (aclk),
      .aresetn (aresetn),
      .din     (evt_raw),
      .dout    (evt_s)
   );

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         evt_prev_q <= '0;
      end else begin
         evt_prev_q <= evt_s;
      end
   end

   assign wake_evt = flags_q[epc_pkg::FLG_EN] & (
                     (evt_s[0] & ~evt_prev_q[0]) |
                     (evt_s[1] & ~evt_prev_q[1] & flags_q[epc_pkg::FLG_PKT]) |
                     (evt_s[2] & ~evt_prev_q[2]) |
                     (evt_s[3] & ~evt_prev_q[3] & flags_q[epc_pkg::FLG_DA]) |
                     (evt_s[4] & ~evt_prev_q[4] & flags_q[epc_pkg::FLG_LINK]));

   epc_wake #(.SHORT_CYC(SHORT_CYC), .LONG_CYC(LONG_CYC)) u_wake (
      .aclk        (aclk),
      .aresetn     (aresetn),
      .flags_valid (flags_valid_q),
      .flags       (flags_q),
      .wake_event  (wake_evt),
      .level_clear (level_clr_q),
      .wake_o      (wake_request_pin_o),
      .wake_oe_n   (wake_request_pin_oe_n),
      .active      (wake_act)
   );

   // AXI4-Lite write channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_q     <= 1'b0;
         w_hold_q      <= 1'b0;
         aw_addr_q     <= '0;
         w_data_q      <= '0;
         w_strb_q      <= '0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= epc_pkg::RESP_OKAY;
         reload_q      <= 1'b0;
         level_clr_q   <= 1'b0;
      end else begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         reload_q      <= 1'b0;
         level_clr_q   <= 1'b0;
         if (s_axi_awvalid && !aw_hold_q && !s_axi_awready && !s_axi_bvalid) begin
            s_axi_awready <= 1'b1;
            aw_hold_q     <= 1'b1;
            aw_addr_q     <= s_axi_awaddr;
         end
         if (s_axi_wvalid && !w_hold_q && !s_axi_wready && !s_axi_bvalid) begin
            s_axi_wready <= 1'b1;
            w_hold_q     <= 1'b1;
            w_data_q     <= s_axi_wdata;
            w_strb_q     <= s_axi_wstrb;
         end
         if (aw_hold_q && w_hold_q && !s_axi_bvalid) begin
            aw_hold_q    <= 1'b0;
            w_hold_q     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= epc_pkg::RESP_OKAY;
            if (aw_addr_q == epc_pkg::REG_CTRL) begin
               if (w_strb_q[0]) begin
                  reload_q    <= w_data_q[0];
                  level_clr_q <= w_data_q[1];
               end
            end else begin
               s_axi_bresp <= epc_pkg::RESP_SLVERR;
            end
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // AXI4-Lite read channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= epc_pkg::RESP_OKAY;
      end else begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= s_axi_rvalid ? !s_axi_rready : s_axi_arready;
         if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
            s_axi_rresp   <= epc_pkg::RESP_OKAY;
            case (s_axi_araddr)
               epc_pkg::REG_CTRL:    s_axi_rdata <= '0;
               epc_pkg::REG_STATUS:  s_axi_rdata <= {29'h0, wake_act, flags_valid_q,
                                                     load_done};
               epc_pkg::REG_FLAGS:   s_axi_rdata <= {24'h0, flags_q};
               epc_pkg::REG_BOS:     s_axi_rdata <= {8'h0, bos_sum_q, bos_ofs_q, bos_len_q};
               epc_pkg::REG_DESC_HS: s_axi_rdata <= pack4(desc_q[0], desc_q[1],
                                                          desc_q[2], desc_q[3]);
               epc_pkg::REG_DESC_FS: s_axi_rdata <= pack4(desc_q[4], desc_q[5],
                                                          desc_q[6], desc_q[7]);
               epc_pkg::REG_WFF_CFG: s_axi_rdata <= pack4(wff_q[0], wff_q[1],
                                                          wff_q[2], wff_q[3]);
               8'h1c: s_axi_rdata <= pack4(wff_q[4], wff_q[5], wff_q[6], wff_q[7]);
               8'h20: s_axi_rdata <= pack4(wff_q[8], wff_q[9], wff_q[10], wff_q[11]);
               8'h24: s_axi_rdata <= pack4(wff_q[12], wff_q[13], wff_q[14], wff_q[15]);
               8'h28: s_axi_rdata <= pack4(wff_q[16], wff_q[17], wff_q[18], wff_q[19]);
               epc_pkg::REG_SW:      s_axi_rdata <= {16'h0, sw_ofs_q, sw_len_q};
               epc_pkg::REG_IF_STR:  s_axi_rdata <= {16'h0, wff_len_q, if_str_ofs_q};
               default: begin
                  s_axi_rdata <= '0;
                  s_axi_rresp <= epc_pkg::RESP_SLVERR;
               end
            endcase
         end
      end
   end
endmodule

/* verif/epc_img_mem.sv */
// Purpose: Byte image memory behind the loader
// Assumes: One read at a time, data due the cycle after img_rd
// Notes:   Data line toggles when no read is answered
`timescale 1ns/100ps
module epc_img_mem (
   input  wire logic       aclk,
   input  wire logic       img_rd,
   input  wire logic [8:0] img_addr,
   output logic      [7:0] img_data
);
   logic [7:0] mem [0:511];
   initial begin
      for (int i = 0; i < 512; i++)
         mem[i] = 8'h00;
      for (int i = 0; i < 20; i++)
         mem[9'h0e0 + i] = 8'h30 + i[7:0];
      mem[9'h009] = 8'hdf;
      mem[9'h02e] = 8'h11;
      mem[9'h02f] = 8'h04;
      mem[9'h030] = 8'h60;
      mem[9'h035] = 8'h12;
      mem[9'h036] = 8'h40;
      mem[9'h037] = 8'h09;
      mem[9'h038] = 8'h41;
      mem[9'h039] = 8'h12;
      mem[9'h03a] = 8'h48;
      mem[9'h03b] = 8'h09;
      mem[9'h03c] = 8'h49;
      mem[9'h03d] = 8'h14;
      mem[9'h03e] = 8'h70;
      mem[9'h041] = 8'h04;
      mem[9'h044] = 8'h02;
      mem[9'h046] = 8'h08;
      mem[9'h047] = 8'h50;
      mem[9'h0c0] = 8'h01;
      mem[9'h0c1] = 8'h02;
      mem[9'h0c2] = 8'h03;
      mem[9'h0c3] = 8'h04;
   end
   always @(posedge aclk)
      img_data <= img_rd ? mem[img_addr] : ~img_data;
endmodule

/* verif/epc_top_props.sv */
// Purpose: Wake pin checks
// Assumes: Flag byte seen on the image read of 09h
// Notes:   Bound to the top
`timescale 1ns/100ps
module epc_top_props #(
   parameter int unsigned SHORT_CYC = 20,
   parameter int unsigned LONG_CYC  = 200
) (
   input wire logic       aclk,
   input wire logic       aresetn,
   input wire logic       s_axi_wvalid,
   input wire logic       img_rd,
   input wire logic [8:0] img_addr,
   input wire logic [7:0] img_data,
   input wire logic       gpio_wake_evt,
   input wire logic       wake_request_pin_o,
   input wire logic       wake_request_pin_oe_n,
   input wire logic       load_done
);
   logic        rd9_q, fok_q, act;
   logic [7:0]  flg_q;
   logic [31:0] cnt_q;
   logic [2:0]  age_q;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   assign act = fok_q && flg_q[7] && !wake_request_pin_oe_n
                && (!flg_q[3] || wake_request_pin_o == flg_q[4]);
   always_ff @(posedge aclk) begin
      rd9_q <= aresetn && img_rd && img_addr == 9'h009;
      fok_q <= aresetn && (fok_q || rd9_q);
      if (rd9_q) flg_q <= img_data;
   end
   always_ff @(posedge aclk)
      cnt_q <= act ? cnt_q + 32'h1 : 32'h0;
   always_ff @(posedge aclk)
      age_q <= (!aresetn || s_axi_wvalid) ? 3'h0 : age_q + {2'h0, age_q != 3'h7};
   AST_IDLE: assert property (!fok_q |-> wake_request_pin_oe_n)
      else $error("wake pin driven before flags loaded");
   AST_DIS: assert property (fok_q && !flg_q[7] |-> wake_request_pin_oe_n)
      else $error("wake pin driven while disabled");
   AST_OD_HI: assert property (fok_q && flg_q[7] && !flg_q[3] && flg_q[4] |-> wake_request_pin_oe_n)
      else $error("open drain active high drove the pin");
   AST_OD_LO: assert property (fok_q && flg_q[7] && !flg_q[3] && !wake_request_pin_oe_n |-> !wake_request_pin_o)
      else $error("open drain drove a high level");
   AST_LOAD: assert property ($rose(load_done) && fok_q && flg_q[7] && flg_q[3] |-> !wake_request_pin_oe_n && wake_request_pin_o != flg_q[4])
      else $error("push-pull pin not driven inactive");
   AST_EVT: assert property (fok_q && flg_q[7] && flg_q[3] && $rose(gpio_wake_evt) |-> ##[2:8] act)
      else $error("event did not assert wake pin");
   AST_PMAX: assert property (act && flg_q[6] |-> cnt_q < (flg_q[5] ? LONG_CYC : SHORT_CYC))
      else $error("pulse too long");
   AST_PLEN: assert property ($fell(act) && flg_q[6] |-> $past(cnt_q) + 1 == (flg_q[5] ? LONG_CYC : SHORT_CYC))
      else $error("pulse length wrong");
   AST_LVL: assert property (act && !flg_q[6] && load_done && age_q == 3'h7 |=> act)
      else $error("level dropped without clear");
   cover property ($fell(act) && flg_q[6] && flg_q[5]);
   cover property ($fell(act) && !flg_q[6]);
   cover property (act && !flg_q[3]);
endmodule
bind epc_top epc_top_props #(.SHORT_CYC(SHORT_CYC), .LONG_CYC(LONG_CYC)) u_props (.*);

/* verif/testbench.sv */
// Purpose: Self-checking bench for the loader and wake pin
// Assumes: Short pulse counts set by parameter
// Notes:   Events are indices 0 gpio 1 packet 2 filter 3 address 4 link
`timescale 1ns/100ps
module testbench;
   localparam int unsigned SC = 20;
   localparam int unsigned LC = 200;
   logic        aclk = 1'b0, aresetn = 1'b0, pol = 1'b1;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, img_data;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp, r;
   logic        img_rd, load_done, wake_request_pin_o, wake_request_pin_oe_n;
   logic [8:0]  img_addr;
   logic [4:0]  ev = 5'h00;
   int          bad_count = 0, cmp_count = 0, n;
   wire act = !wake_request_pin_oe_n && wake_request_pin_o == pol;
   always #12.5 aclk = ~aclk;
   epc_top #(.SHORT_CYC(SC), .LONG_CYC(LC)) dut (.*, .gpio_wake_evt(ev[0]), .packet_evt(ev[1]),
      .wake_frame_filter_match(ev[2]), .exact_destination_match(ev[3]), .link_change_evt(ev[4]));
   epc_img_mem img (.*);
   task automatic tally_and_finish();
      $display("comparisons %0d, mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input logic [33:0] g, input logic [33:0] e);
      cmp_count++;
      if (g !== e) begin
         bad_count++;
         $display("unexpected at %0t: got %h, expected %h", $time, g, e);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge aclk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task automatic fire(input int k);
      @(posedge aclk);
      ev[k] <= 1'b1;
      repeat (4) @(posedge aclk);
      ev[k] <= 1'b0;
   endtask
   task automatic pw();
      n = 0;
      for (int i = 0; i < 12 && act !== 1'b1; i++) tick(1);
      while (act === 1'b1 && n < 400) begin
         n++;
         tick(1);
      end
   endtask
   task automatic cfg(input logic [7:0] f, input logic p);
      img.mem[9] = f;
      pol = p;
      wr(8'h00, 32'h1);
      for (int i = 0; i < 20 && load_done; i++) tick(1);
      for (int i = 0; i < 2000 && !load_done; i++) tick(1);
      chk(load_done, 1'b1);
   endtask
   task automatic t_regs();
      logic [7:0]  ra [10] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c,
                              8'h2c, 8'h30};
      logic [31:0] rv [10] = '{32'h0, 32'h3, 32'hdf, 32'h000a6004, 32'h41094012,
                              32'h49094812, 32'h33323130, 32'h37363534, 32'h5008, 32'h1411};
      chk({wake_request_pin_o, wake_request_pin_oe_n}, 2'b00);
      for (int i = 0; i < 10; i++) begin
         rd(ra[i]);
         chk({r, d}, {epc_pkg::RESP_OKAY, rv[i]});
      end
      rd(8'h40);
      chk({r, d}, {epc_pkg::RESP_SLVERR, 32'h0});
      wr(8'h40, 32'h1);
      chk(r, epc_pkg::RESP_SLVERR);
   endtask
   task automatic t_pulse(input logic [7:0] f, input int a, input int b, input int len);
      cfg(f, 1'b1);
      fork
         pw();
         begin
            fire(a);
            repeat (len / 2) @(posedge aclk);
            fire(b);
         end
      join
      chk(n, len);
   endtask
   task automatic t_level();
      cfg(8'h8f, 1'b0);
      fire(4);
      tick(30);
      chk(act, 1'b1);
      wr(8'h00, 32'h2);
      tick(4);
      chk(act, 1'b0);
   endtask
   task automatic t_gate();
      cfg(8'h9b, 1'b1);
      fire(4);
      tick(10);
      chk(act, 1'b0);
      fire(1);
      tick(8);
      chk(act, 1'b1);
      wr(8'h00, 32'h2);
      cfg(8'h9c, 1'b1);
      fire(1);
      fire(3);
      tick(8);
      chk(act, 1'b0);
      fire(0);
      tick(8);
      chk(act, 1'b1);
      wr(8'h00, 32'h2);
   endtask
   task automatic t_drive();
      cfg(8'h7f, 1'b1);
      fire(0);
      fire(4);
      tick(8);
      chk(wake_request_pin_oe_n, 1'b1);
      cfg(8'hc0, 1'b0);
      fork
         pw();
         fire(2);
      join
      chk(n, SC);
      cfg(8'h90, 1'b1);
      fire(0);
      tick(8);
      chk(wake_request_pin_oe_n, 1'b1);
      wr(8'h00, 32'h2);
   endtask
   initial begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      tick(1);
      chk(wake_request_pin_oe_n, 1'b1);
      for (int i = 0; i < 2000 && !load_done; i++) tick(1);
      t_regs();
      t_pulse(8'hdf, 1, 3, SC);
      t_pulse(8'hff, 3, 0, LC);
      t_level();
      t_gate();
      t_drive();
      tally_and_finish();
   end
   initial begin
      #500000;
      bad_count++;
      tally_and_finish();
   end
endmodule
